// ==== dv/ippm_checker.sv ====
// Purpose: port checks of the priority and power mode core
// Assumes: one clock, synchronous active-high reset
// Notes: idle and settle are told apart by the peripheral enable
`timescale 1ns/1ns
module ippm_checker #(
    parameter SETTLE_CYC = 50
) (
    input wire clk_i,
    input wire reset_i,
    input wire instr_done_i,
    input wire ext_a_n_i,
    input wire ext_b_n_i,
    input wire ext_prog_i,
    input wire cpu_clk_en_o,
    input wire periph_clk_en_o,
    input wire osc_stop_o,
    input wire irq_take_o,
    input wire [2:0] irq_src_o,
    input wire ale_o,
    input wire program_fetch_strobe_o,
    input wire port_hold_o,
    input wire port0_float_o,
    input wire port2_addr_o
);
    // =====================================================
    // settle length, so an early wake is caught
    reg [15:0] settle_cnt_reg;
    always @(posedge clk_i) begin
        if (reset_i || periph_clk_en_o || osc_stop_o) begin
            settle_cnt_reg <= 16'h0000;
        end else begin
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence settle_s;
        !periph_clk_en_o && !osc_stop_o;
    endsequence
    sequence wake_take_s;
        ##[0:3] irq_take_o && (irq_src_o == 3'h0 || irq_src_o == 3'h2);
    endsequence
    // =====================================================
    // assertions
    idle_strobes_a: assert property ((!cpu_clk_en_o && periph_clk_en_o) |->
        ale_o && program_fetch_strobe_o && port_hold_o) else $error("idle strobes wrong");
    down_pins_a: assert property (osc_stop_o |-> !ale_o && !program_fetch_strobe_o && port_hold_o
        && !port2_addr_o) else $error("power-down pins wrong");
    down_clocks_a: assert property (osc_stop_o |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("clock runs in power-down");
    idle_periph_a: assert property (port2_addr_o |-> periph_clk_en_o && !cpu_clk_en_o
        && ext_prog_i) else $error("idle peripheral clock wrong");
    port0_float_a: assert property (port0_float_o |-> port_hold_o)
        else $error("port 0 floats outside low power");
    down_stays_a: assert property ((osc_stop_o && ext_a_n_i && ext_b_n_i) |=> osc_stop_o)
        else $error("power-down left without pin");
    wake_pin_a: assert property ($fell(osc_stop_o) |-> !ext_a_n_i || !ext_b_n_i)
        else $error("oscillator restarted without low pin");
    settle_min_a: assert property (settle_s ##1 periph_clk_en_o |->
        settle_cnt_reg >= SETTLE_CYC) else $error("settle too short");
    wake_vector_a: assert property (settle_s ##1 periph_clk_en_o |->
        (($past(irq_take_o) || $past(irq_take_o, 2)) && irq_src_o[0] == 1'b0)
        or wake_take_s) else $error("no wake vector");
    idle_entry_a: assert property ($fell(cpu_clk_en_o) |-> $past(instr_done_i) ||
        $past(instr_done_i, 2) || $past(instr_done_i, 3)) else $error("cpu stopped early");
endmodule
bind ippm_core ippm_checker #(.SETTLE_CYC(SETTLE_CYC)) chk_i (.clk_i, .reset_i,
    .instr_done_i, .ext_a_n_i, .ext_b_n_i, .ext_prog_i, .cpu_clk_en_o, .periph_clk_en_o,
    .osc_stop_o, .irq_take_o, .irq_src_o, .ale_o, .program_fetch_strobe_o, .port_hold_o, .port0_float_o,
    .port2_addr_o);

// ==== dv/ippm_pin_model.sv ====
// Purpose: external wake pins as the board drives them
// Assumes: pins pulled up when released
// Notes: pins held low well past the settle time
`timescale 1ns/1ns
module ippm_pin_model (
    input wire clk_i,
    output reg ext_a_n_o,
    output reg ext_b_n_o
);
    initial begin
        ext_a_n_o = 1'b1;
        ext_b_n_o = 1'b1;
    end
    // pull low, release a after na and b after nb cycles; zero leaves a pin high
    task automatic wake(input int na, input int nb);
        int i;
        begin
            for (i = 0; i <= na || i <= nb; i = i + 1) begin
                @(posedge clk_i);
                ext_a_n_o <= (i < na) ? 1'b0 : 1'b1;
                ext_b_n_o <= (i < nb) ? 1'b0 : 1'b1;
            end
        end
    endtask
endmodule

// ==== dv/test_irq_priority_power_modes.sv ====
// Purpose: register, priority, idle and power-down sequences
// Assumes: settle shortened to 4 cycles
// Notes: addresses come from the register map constants except the unmapped 8'h10 read, expected values are literals
`timescale 1ns/1ns
`include "ippm_defines.vh"
module test_irq_priority_power_modes;
    reg clk_i, reset_i, wr_i, rd_i, bit_wr_i, instr_done_i, return_from_interrupt_i, ext_prog_i;
    reg [7:0] addr_i, wdata_i;
    reg [2:0] bit_sel_i;
    reg [5:0] irq_i;
    wire [7:0] rdata_o;
    wire [2:0] irq_src_o;
    wire ext_a_n, ext_b_n, cpu_en, per_en, osc, take_o, ale, program_fetch_strobe, hold, p0f, p2a;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    ippm_core #(.SETTLE_CYC(4)) uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .bit_wr_i(bit_wr_i),
        .bit_sel_i(bit_sel_i), .rdata_o(rdata_o), .instr_done_i(instr_done_i),
        .irq_i(irq_i), .ext_a_n_i(ext_a_n), .ext_b_n_i(ext_b_n), .return_from_interrupt_i(return_from_interrupt_i),
        .ext_prog_i(ext_prog_i), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
        .osc_stop_o(osc), .irq_take_o(take_o), .irq_src_o(irq_src_o), .ale_o(ale),
        .program_fetch_strobe_o(program_fetch_strobe), .port_hold_o(hold), .port0_float_o(p0f), .port2_addr_o(p2a));
    ippm_pin_model pm (.clk_i(clk_i), .ext_a_n_o(ext_a_n), .ext_b_n_o(ext_b_n));
    // =====================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw,
        input logic [2:0] bs);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            bit_wr_i <= bw;
            bit_sel_i <= bs;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            bit_wr_i <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1;
            chk(rdata_o, exp);
        end
    endtask
    // one-cycle pulse: 0 retires an instruction, 1 returns from a handler
    task automatic pulse(input int which);
        begin
            @(posedge clk_i);
            instr_done_i <= (which == 0);
            return_from_interrupt_i <= (which == 1);
            @(posedge clk_i);
            instr_done_i <= 1'b0;
            return_from_interrupt_i <= 1'b0;
        end
    endtask
    task automatic setirq(input logic [5:0] v);
        begin
            @(posedge clk_i);
            irq_i <= v;
        end
    endtask
    task automatic take(input logic [2:0] src, input int lim);
        int n;
        begin
            n = 0;
            #1;
            while (take_o !== 1'b1 && n < lim) begin
                @(posedge clk_i);
                #1;
                n = n + 1;
            end
            chk({4'h0, take_o, irq_src_o}, {5'h01, src});
        end
    endtask
    task automatic no_take(input int lim);
        int n;
        logic [7:0] seen;
        begin
            seen = 8'h00;
            for (n = 0; n < lim; n = n + 1) begin
                @(posedge clk_i);
                #1;
                if (take_o !== 1'b0) seen = seen + 8'h01;
            end
            chk(seen, 8'h00);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    // =====================================================
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    // =====================================================
    // main sequence
    initial begin
        {reset_i, wr_i, rd_i, bit_wr_i, instr_done_i, return_from_interrupt_i, ext_prog_i} = 7'h41;
        {addr_i, wdata_i, bit_sel_i, irq_i} = 25'h0;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(`IPPM_ADDR_PRIO_LOW, 8'h00);
        wr(`IPPM_ADDR_PRIO_LOW, 8'h3F, 1'b0, 3'h0);
        rd(`IPPM_ADDR_PRIO_LOW, 8'h3F);
        wr(`IPPM_ADDR_PRIO_LOW, 8'h00, 1'b1, 3'h5);
        rd(`IPPM_ADDR_PRIO_LOW, 8'h1F);
        wr(`IPPM_ADDR_PRIO_HIGH, 8'h3F, 1'b0, 3'h0);
        wr(`IPPM_ADDR_PRIO_HIGH, 8'h00, 1'b1, 3'h5);
        rd(`IPPM_ADDR_PRIO_HIGH, 8'h3F);
        rd(8'h10, 8'h00);
        wr(`IPPM_ADDR_POWER, 8'h0C, 1'b0, 3'h0);
        rd(`IPPM_ADDR_POWER, 8'h0C);
        chk({7'h0, cpu_en}, 8'h01);
        // serial at level 2 and timer 1 at level 1 arrive together
        wr(`IPPM_ADDR_ENABLE, 8'hBF, 1'b0, 3'h0);
        wr(`IPPM_ADDR_PRIO_LOW, 8'h0A, 1'b0, 3'h0);
        wr(`IPPM_ADDR_PRIO_HIGH, 8'h12, 1'b0, 3'h0);
        setirq(6'h18);
        take(3'h4, 8);
        setirq(6'h08);
        no_take(6);
        setirq(6'h0A);
        take(3'h1, 8);
        setirq(6'h08);
        pulse(1);
        no_take(4);
        pulse(1);
        take(3'h3, 8);
        setirq(6'h00);
        pulse(1);
        // equal levels fall back to poll order
        wr(`IPPM_ADDR_PRIO_LOW, 8'h00, 1'b0, 3'h0);
        wr(`IPPM_ADDR_PRIO_HIGH, 8'h00, 1'b0, 3'h0);
        setirq(6'h22);
        take(3'h1, 8);
        setirq(6'h00);
        pulse(1);
        // idle, left by an enabled interrupt
        wr(`IPPM_ADDR_PRIO_LOW, 8'h15, 1'b0, 3'h0);
        wr(`IPPM_ADDR_PRIO_HIGH, 8'h04, 1'b0, 3'h0);
        wr(`IPPM_ADDR_POWER, 8'h0D, 1'b0, 3'h0);
        pulse(0);
        repeat (3) @(posedge clk_i);
        #1;
        chk({2'h0, cpu_en, per_en, ale, program_fetch_strobe, p2a, p0f}, 8'h1F);
        setirq(6'h02);
        take(3'h1, 8);
        setirq(6'h00);
        repeat (3) @(posedge clk_i);
        #1;
        chk({7'h0, cpu_en}, 8'h01);
        rd(`IPPM_ADDR_POWER, 8'h0C);
        pulse(1);
        // power-down with both bits, woken by pin a alone
        wr(`IPPM_ADDR_POWER, 8'h0F, 1'b0, 3'h0);
        pulse(0);
        repeat (3) @(posedge clk_i);
        #1;
        chk({3'h0, osc, ale, program_fetch_strobe, hold, cpu_en}, 8'h12);
        setirq(6'h02);
        no_take(8);
        setirq(6'h00);
        fork
            pm.wake(20, 0);
            take(3'h0, 40);
        join
        repeat (3) @(posedge clk_i);
        #1;
        chk({6'h0, osc, cpu_en}, 8'h01);
        rd(`IPPM_ADDR_POWER, 8'h0C);
        rd(`IPPM_ADDR_PRIO_LOW, 8'h15);
        setirq(6'h02);
        no_take(4);
        setirq(6'h00);
        pulse(1);
        // both pins low, a released first, b holds the higher level
        wr(`IPPM_ADDR_POWER, 8'h02, 1'b0, 3'h0);
        pulse(0);
        repeat (3) @(posedge clk_i);
        fork
            pm.wake(15, 25);
            take(3'h2, 40);
        join
        pulse(1);
        // idle ended by a short reset
        wr(`IPPM_ADDR_POWER, 8'h01, 1'b0, 3'h0);
        pulse(0);
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (24) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({7'h0, cpu_en}, 8'h01);
        rd(`IPPM_ADDR_PRIO_LOW, 8'h00);
        report_and_stop;
    end
endmodule

// ==== logic/ippm_arbiter.v ====
// Purpose: pick the winning interrupt source by level then poll order
// Assumes: pending bits already gated by enables
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ns
`include "ippm_defines.vh"
module ippm_arbiter #(
    parameter NSRC = 6
) (
    input wire [NSRC-1:0] pend_i, // gated requests
    input wire [NSRC-1:0] prio_low_i, // low priority bits
    input wire [NSRC-1:0] prio_high_i, // high priority bits
    output reg found_o, // some request pending
    output reg [2:0] src_o, // winning source index
    output reg [1:0] level_o // winning level
);
    integer k;
    reg [1:0] lv;
    // =====================================================
    // scan from last source down so lowest index wins ties
    always @* begin
        found_o = 1'b0;
        src_o = 3'h0;
        level_o = 2'h0;
        lv = 2'h0;
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            lv = {prio_high_i[k], prio_low_i[k]}; // RL4
            // higher level, or equal level earlier in poll order
            if (pend_i[k] && (!found_o || lv >= level_o)) begin // RL6
                found_o = 1'b1;
                src_o = k[2:0];
                level_o = lv;
            end
        end
    end
endmodule

// ==== logic/ippm_core.v ====
// Purpose: interrupt priority registers, arbitration, idle and power-down
// Assumes: cpu signals and pins synchronous to clk_i
// Notes: clocks leave as enables; the oscillator stop is a request output
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "ippm_defines.vh"
module ippm_core #(
    parameter NSRC = 6,
    parameter SETTLE_CYC = (`IPPM_SETTLE_NS + `IPPM_CLK_NS - 1) / `IPPM_CLK_NS
) (
    input wire clk_i, // oscillator clock
    input wire reset_i, // synchronous reset
    input wire [7:0] addr_i, // register address
    input wire [7:0] wdata_i, // write data
    input wire wr_i, // write strobe
    input wire rd_i, // read strobe
    input wire bit_wr_i, // single-bit write
    input wire [2:0] bit_sel_i, // bit index for single-bit write
    output reg [7:0] rdata_o, // read data, one cycle later
    input wire instr_done_i, // current instruction retired
    input wire [NSRC-1:0] irq_i, // source requests
    input wire ext_a_n_i, // external pin a, active low
    input wire ext_b_n_i, // external pin b, active low
    input wire return_from_interrupt_i, // return from interrupt
    input wire ext_prog_i, // program memory is external
    output reg cpu_clk_en_o, // cpu clock enable
    output reg periph_clk_en_o, // peripheral clock enable
    output reg osc_stop_o, // stop the oscillator
    output reg irq_take_o, // vector to a handler, pulse
    output reg [2:0] irq_src_o, // vectored source
    output reg ale_o, // address latch strobe
    output reg program_fetch_strobe_o, // program fetch strobe
    output reg port_hold_o, // ports keep latched data
    output reg port0_float_o, // port 0 released
    output reg port2_addr_o // port 2 carries address
);
    // =====================================================
    // power states
    localparam ST_RUN = 2'b00;
    localparam ST_IDLE = 2'b01;
    localparam ST_DOWN = 2'b10;
    localparam ST_SETTLE = 2'b11;
    localparam [15:0] SETTLE_MAX = SETTLE_CYC[15:0];

    reg [7:0] prio_low_reg; // low priority bits
    reg [7:0] prio_high_reg; // high priority bits
    reg [7:0] power_reg; // power control
    reg [7:0] enable_reg; // interrupt enables
    reg [1:0] state_reg; // power state
    reg [1:0] state_next;
    reg [15:0] settle_reg; // oscillator settle count
    reg [3:0] active_reg; // in-service levels, one bit per level
    reg [1:0] cur_level_reg; // highest level in service
    reg wake_a_seen_reg; // pin a went low during power-down
    reg wake_b_seen_reg; // pin b went low during power-down
    reg pend_arm_reg; // idle or down entry pending
    reg [7:0] rd_data;
    wire found;
    wire [2:0] win_src;
    wire [1:0] win_level;
    wire [NSRC-1:0] pend;
    wire wake_a;
    wire wake_b;
    wire arm_a;
    wire arm_b;
    wire preempt_ok;
    wire take;
    wire [1:0] lv_a; // pin a level
    wire [1:0] lv_b; // pin b level
    wire pick_b; // wake vector goes to pin b

    // =====================================================
    // decode helper, used by every write path
    function hit;
        input [7:0] a;
        input [7:0] want;
        begin
            hit = (a == want);
        end
    endfunction

    assign pend = irq_i & enable_reg[NSRC-1:0] & {NSRC{enable_reg[`IPPM_EN_ALL_BIT]}};

    ippm_arbiter #(.NSRC(NSRC)) u_arb (
        .pend_i(pend),
        .prio_low_i(prio_low_reg[NSRC-1:0]),
        .prio_high_i(prio_high_reg[NSRC-1:0]),
        .found_o(found),
        .src_o(win_src),
        .level_o(win_level)
    );

    // =====================================================
    // wake capture works with the clock stopped
    assign arm_a = (state_reg == ST_DOWN) & enable_reg[`IPPM_SRC_EXT_A]
                   & enable_reg[`IPPM_EN_ALL_BIT]; // RL15
    assign arm_b = (state_reg == ST_DOWN) & enable_reg[`IPPM_SRC_EXT_B]
                   & enable_reg[`IPPM_EN_ALL_BIT]; // RL15
    ippm_wake_latch u_wake_a (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .arm_i(arm_a),
        .pin_n_i(ext_a_n_i),
        .clear_i(state_reg == ST_RUN),
        .wake_o(wake_a)
    );
    ippm_wake_latch u_wake_b (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .arm_i(arm_b),
        .pin_n_i(ext_b_n_i),
        .clear_i(state_reg == ST_RUN),
        .wake_o(wake_b)
    );

    // preempt only from a strictly higher level; level 3 never preempted
    assign preempt_ok = (active_reg == 4'h0) || (win_level > cur_level_reg); // RL5
    assign take = found && preempt_ok && (state_reg == ST_RUN || state_reg == ST_IDLE);
    // equal levels fall back to poll order, so pin a wins a tie
    assign lv_a = {prio_high_reg[`IPPM_SRC_EXT_A], prio_low_reg[`IPPM_SRC_EXT_A]};
    assign lv_b = {prio_high_reg[`IPPM_SRC_EXT_B], prio_low_reg[`IPPM_SRC_EXT_B]};
    assign pick_b = wake_b && (!wake_a || lv_b > lv_a); // RL17

    // =====================================================
    // power state sequencing
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                // entry waits for the setting instruction to retire
                if (pend_arm_reg && instr_done_i) begin // RL7
                    if (power_reg[`IPPM_DEEP_BIT]) begin
                        state_next = ST_DOWN; // RL14 RL20
                    end else if (power_reg[`IPPM_SLEEP_BIT]) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_RUN; // RL11
                end
            end
            ST_DOWN: begin
                // oscillator runs again once any armed pin is low
                if (wake_a || wake_b) begin // RL16 RL17
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // first released pin completes the exit after settling
                if (settle_reg >= SETTLE_MAX &&
                    ((wake_a && ext_a_n_i) || (wake_b && ext_b_n_i))) begin // RL16 RL17 RL22
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // =====================================================
    // state, settle count and entry tracking
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= ST_RUN; // RL12 RL19
            settle_reg <= 16'h0000;
            pend_arm_reg <= 1'b0;
            wake_a_seen_reg <= 1'b0;
            wake_b_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_SETTLE) begin
                if (settle_reg < SETTLE_MAX) begin
                    settle_reg <= settle_reg + 16'h0001;
                end
            end else begin
                settle_reg <= 16'h0000;
            end
            // a write setting sleep or deep arms entry at retirement
            if (wr_i && hit(addr_i, `IPPM_ADDR_POWER) &&
                (wdata_i[`IPPM_SLEEP_BIT] || wdata_i[`IPPM_DEEP_BIT])) begin
                pend_arm_reg <= 1'b1;
            end else if (instr_done_i) begin
                pend_arm_reg <= 1'b0;
            end
            wake_a_seen_reg <= wake_a;
            wake_b_seen_reg <= wake_b;
        end
    end

    // =====================================================
    // registers: priority, power control, enables
    always @(posedge clk_i) begin
        if (reset_i) begin
            prio_low_reg <= `IPPM_RESET_BYTE;
            prio_high_reg <= `IPPM_RESET_BYTE;
            power_reg <= `IPPM_RESET_BYTE;
            enable_reg <= `IPPM_RESET_BYTE;
        end else begin
            if (wr_i && hit(addr_i, `IPPM_ADDR_PRIO_LOW)) begin
                if (bit_wr_i) begin
                    // single-bit write only on the low bits
                    prio_low_reg[bit_sel_i] <= wdata_i[0]; // RL3
                end else begin
                    prio_low_reg <= wdata_i; // RL1
                end
            end
            // whole byte only; bit writes to this address are ignored
            if (wr_i && !bit_wr_i && hit(addr_i, `IPPM_ADDR_PRIO_HIGH)) begin
                prio_high_reg <= wdata_i; // RL3
            end
            if (wr_i && !bit_wr_i && hit(addr_i, `IPPM_ADDR_ENABLE)) begin
                enable_reg <= wdata_i & `IPPM_ENABLE_MASK;
            end
            // hardware clear beats software set: the wake must stick
            if (wr_i && !bit_wr_i && hit(addr_i, `IPPM_ADDR_POWER)) begin
                power_reg <= wdata_i & `IPPM_POWER_MASK; // RL13
            end
            if ((state_reg == ST_IDLE && take) ||
                (state_reg == ST_SETTLE && state_next == ST_RUN)) begin
                power_reg[`IPPM_SLEEP_BIT] <= 1'b0; // RL11 RL20
                power_reg[`IPPM_DEEP_BIT] <= 1'b0; // RL20
            end
        end
    end

    // =====================================================
    // in-service level stack and vectoring
    always @(posedge clk_i) begin
        if (reset_i) begin
            active_reg <= 4'h0;
            cur_level_reg <= 2'h0;
            irq_take_o <= 1'b0;
            irq_src_o <= 3'h0;
        end else begin
            irq_take_o <= 1'b0;
            if (take) begin
                active_reg[win_level] <= 1'b1;
                cur_level_reg <= win_level;
                irq_take_o <= 1'b1; // RL6 RL11
                irq_src_o <= win_src;
            end else if (state_reg == ST_SETTLE && state_next == ST_RUN) begin
                // wake vector: released pin, higher level if both were low
                irq_take_o <= 1'b1; // RL17 RL18
                irq_src_o <= pick_b ? 3'h2 : 3'h0;
                active_reg[pick_b ? lv_b : lv_a] <= 1'b1; // RL5
                cur_level_reg <= pick_b ? lv_b : lv_a;
            end else if (return_from_interrupt_i && active_reg != 4'h0) begin
                // pop the highest active level
                active_reg[cur_level_reg] <= 1'b0;
                if (cur_level_reg == 2'h3 && active_reg[2]) begin
                    cur_level_reg <= 2'h2;
                end else if (cur_level_reg >= 2'h2 && active_reg[1]) begin
                    cur_level_reg <= 2'h1;
                end else begin
                    cur_level_reg <= 2'h0;
                end
            end
        end
    end

    // =====================================================
    // read mux; reserved bits read zero
    always @* begin
        case (addr_i)
            `IPPM_ADDR_PRIO_LOW: rd_data = prio_low_reg & `IPPM_PRIO_MASK; // RL2
            `IPPM_ADDR_PRIO_HIGH: rd_data = prio_high_reg & `IPPM_PRIO_MASK; // RL2
            `IPPM_ADDR_POWER: rd_data = power_reg;
            `IPPM_ADDR_ENABLE: rd_data = enable_reg;
            `IPPM_ADDR_STATUS: rd_data = {3'h0, wake_b_seen_reg, wake_a_seen_reg,
                                         1'b0, state_reg};
            default: rd_data = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_data : 8'h00;
        end
    end

    // =====================================================
    // clock enables and pin behaviour per mode
    always @(posedge clk_i) begin
        if (reset_i) begin
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_stop_o <= 1'b0;
            ale_o <= 1'b1;
            program_fetch_strobe_o <= 1'b1;
            port_hold_o <= 1'b0;
            port0_float_o <= 1'b0;
            port2_addr_o <= 1'b0;
        end else begin
            // cpu frozen in idle so its state is retained
            cpu_clk_en_o <= (state_next == ST_RUN); // RL8 RL9
            periph_clk_en_o <= (state_next == ST_RUN || state_next == ST_IDLE); // RL8
            osc_stop_o <= (state_next == ST_DOWN); // RL14
            ale_o <= (state_next != ST_DOWN && state_next != ST_SETTLE); // RL10 RL21
            program_fetch_strobe_o <= (state_next != ST_DOWN && state_next != ST_SETTLE); // RL10 RL21
            port_hold_o <= (state_next != ST_RUN); // RL9 RL21
            port0_float_o <= (state_next != ST_RUN) && ext_prog_i; // RL21
            port2_addr_o <= (state_next == ST_IDLE) && ext_prog_i; // RL21
        end
    end
endmodule

// ==== logic/ippm_defines.vh ====
// Purpose: constants for the interrupt priority and power mode block
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses on the plain register port
// Function
// [RL1] low priority bits, one per source
// [RL2] bits 7 and 6 reserved, never write one
// [RL3] low bitwise, high bytewise, same positions
// [RL4] high and low bits form level 0-3
// [RL5] preempt only by strictly higher level
// [RL6] highest level first, then fixed poll order
// [RL7] sleep bit write finishes instruction, then idle
// [RL8] idle gates cpu clock, peripherals keep running
// [RL9] idle retains cpu state and pin levels
// [RL10] idle drives both strobes high
// [RL11] enabled interrupt clears sleep bit, ends idle
// [RL12] reset ends idle, two machine cycles
// [RL13] two general flags, no side effect
// [RL14] power-down stops oscillator, contents kept
// [RL15] power-down exit by reset or external irq
// [RL16] low pin restarts oscillator, high completes wake
// [RL17] first released pin wakes, higher priority served
// [RL18] resume after the power-down instruction
// [RL19] reset exit reinitialises, irq exit keeps registers
// [RL20] both bits set behaves as power-down, clears both
// [RL21] power-down strobes low, ports hold data
// [RL22] party holds wake source until oscillator stable
// [RL23] wake low detection needs no running clock
`ifndef IPPM_DEFINES_VH
`define IPPM_DEFINES_VH
// =====================================================
// register map
`define IPPM_ADDR_PRIO_LOW 8'hB8
`define IPPM_ADDR_PRIO_HIGH 8'hB7
`define IPPM_ADDR_POWER 8'h87
`define IPPM_ADDR_ENABLE 8'hA8
`define IPPM_ADDR_STATUS 8'hB6
// =====================================================
// field positions
`define IPPM_SLEEP_BIT 0
`define IPPM_DEEP_BIT 1
`define IPPM_FLAG_A_BIT 2
`define IPPM_FLAG_B_BIT 3
`define IPPM_EN_ALL_BIT 7
`define IPPM_SRC_EXT_A 0
`define IPPM_SRC_EXT_B 2
`define IPPM_PRIO_MASK 8'h3F
`define IPPM_POWER_MASK 8'h0F
`define IPPM_ENABLE_MASK 8'hBF
// =====================================================
// reset values and timing
`define IPPM_RESET_BYTE 8'h00
`define IPPM_SETTLE_NS 1000
`define IPPM_CLK_NS 20
`endif

// ==== logic/ippm_wake_latch.v ====
// Purpose: hold a wake request raised while the clock is stopped
// Assumes: pins are active low, arm is a steady level in power-down
// Notes: the asynchronous set is a pin level, not a data load
`timescale 1ns/1ns
module ippm_wake_latch (
    input wire clk_i, // may be stopped
    input wire reset_i, // clears the request
    input wire arm_i, // power-down and pin enabled
    input wire pin_n_i, // external pin, active low
    input wire clear_i, // clock domain acknowledge
    output reg wake_o // request the oscillator
);
    wire set_async;
    assign set_async = arm_i & ~pin_n_i;
    // =====================================================
    // set without clock so a stopped oscillator can restart
    always @(posedge clk_i or posedge set_async) begin
        if (set_async) begin
            wake_o <= 1'b1; // RL23
        end else if (reset_i || clear_i) begin
            wake_o <= 1'b0;
        end
    end
endmodule
